// [logic/i2c_link_pkg.sv]
package i2c_link_pkg;
	// Byte and address layout
	localparam int         BYTE_BITS    = 8;
	localparam int         ADDR_LSB     = 1;
	localparam logic [2:0] MODE_I2C     = 3'h6;
	// Receive buffer depth in bytes
	localparam int         FIFO_WORDS   = 32;
	// Timing of the master's clock divider
	localparam int         SYS_PERIOD_PS = 10000;
	localparam int         QUARTER_NS    = 250;
	localparam int         QUARTER_CYC   =
		(QUARTER_NS * 1000 + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
	// Frame of one transfer: address, ack, data, ack
	localparam int         ACK_A_IDX    = 8;
	localparam int         LAST_IDX     = 17;
endpackage

// [logic/i2c_link_if.sv]
`timescale 1ns/1ps
interface i2c_link_if;
	logic devSclOut;
	logic devSclOe;
	logic devSdaOut;
	logic devSdaOe;
	logic mstSclOut;
	logic mstSclOe;
	logic mstSdaOut;
	logic mstSdaOe;
	logic scl;
	logic sda;

	// Open drain with pull-up: low while any enabled driver pulls low
	assign scl = !((devSclOe && !devSclOut) || (mstSclOe && !mstSclOut));
	assign sda = !((devSdaOe && !devSdaOut) || (mstSdaOe && !mstSdaOut));

	modport dev (input scl, sda,
		output devSclOut, devSclOe, devSdaOut, devSdaOe);
	modport mst (input scl, sda,
		output mstSclOut, mstSclOe, mstSdaOut, mstSdaOe);
endinterface

// [logic/i2c_slave_interface.sv]
`timescale 1ns/1ps
module fifo_buffer #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input  wire logic             mclk,
	input  wire logic             rst,
	input  wire logic             clkEn,
	// Filling side
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	// Draining side
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wrPtr_q;
	logic [AW:0]      rdPtr_q;

	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH) begin : badDepth
			$error("fifo_buffer depth must be a power of two");
		end
	endgenerate

	// Extra pointer bit tells full from empty
	assign outValid = wrPtr_q != rdPtr_q;
	assign inReady  = wrPtr_q != {~rdPtr_q[AW], rdPtr_q[AW-1:0]};
	assign outData  = mem[rdPtr_q[AW-1:0]];

	// Storage has no reset, only the pointers need one
	always_ff @(posedge mclk) begin
		if (clkEn && inValid && inReady) begin
			mem[wrPtr_q[AW-1:0]] <= inData;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
		end else if (clkEn) begin
			if (inValid && inReady) begin
				wrPtr_q <= wrPtr_q + 1'b1;
			end
			if (outValid && outReady) begin
				rdPtr_q <= rdPtr_q + 1'b1;
			end
		end
	end
endmodule

// Rules for this block, the bus master and software
// RULE1: Address-match flag follows address comparison result
// RULE2: Byte-done flag low while shifting, set after 8
// RULE3: Own address in bits 7..1, bit 0 ignored
// RULE4: Selected only when sent address matches own
// RULE5: Address arrives seven bits, MSB first
// RULE6: Match sets flag and raises interrupt request
// RULE7: Eighth bit stored as read/write status
// RULE8: Software loads address, enables, then enables interrupt
// RULE9: Only the master issues START
// RULE10: START sets bus-busy flag
// RULE11: START is data falling while clock high
// RULE12: Matched address acknowledged low on ninth clock
// RULE13: Clock held until software writes or dummy-reads; after a received data byte, held only while the receive buffer is full
// RULE14: Software sets mode bit from read/write bit
// RULE15: Master stops after missing address acknowledge
// RULE16: Data bytes eight bits, MSB first
// RULE17: Receiver acknowledges low after each byte; the bus master leaves the byte it reads unacknowledged
// RULE18: Transmitter records acknowledge, releases on none
// RULE19: Receiver sends ack-to-send bit on ninth clock
// RULE20: Every byte passes through the data register; the received address byte never reaches rxData
// RULE21: STOP clears bus-busy flag
// RULE22: Mode bits must be 110 for this function
// RULE23: Disabled interface floats both lines
// RULE24: Mismatch: no acknowledge, ignore until START
module i2c_slave_interface
	import i2c_link_pkg::*;
#(
	parameter int RX_DEPTH = FIFO_WORDS
) (
	// Clock, reset and clock enable
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic       clkEn,
	// Two-wire link
	i2c_link_if.dev         link,
	// Control bits from software
	input  wire logic [7:0] ownSlaveAddress,
	input  wire logic       serialIfEnable,
	input  wire logic [2:0] serialModeBits,
	input  wire logic       txRxSelect,
	input  wire logic       ackToSend,
	// Data register access
	input  wire logic       txWrite,
	input  wire logic [7:0] txData,
	input  wire logic       dummyRead,
	output logic            rxValid,
	input  wire logic       rxReady,
	output logic      [7:0] rxData,
	// Status and interrupt request
	output logic            addrMatchFlag,
	output logic            byteDoneFlag,
	output logic            busBusyFlag,
	output logic            masterRwBit,
	output logic            receivedAckFlag,
	output logic            serialIrq
);
	typedef enum logic [3:0] {
		IDLE, ADDR, ADDR_ACK, HOLD, RX, RX_ACK, TX, TX_ACK, IGNORE
	} devState_t;

	localparam logic [3:0] LAST_BIT = 4'(BYTE_BITS - 1);
	localparam logic [3:0] ALL_BITS = 4'(BYTE_BITS);

	devState_t  state_q;
	logic [3:0] cnt_q;
	logic [1:0] phase_q;
	logic [7:0] shift_q;
	logic       sclOe_q;
	logic       sdaOe_q;
	logic       sclMeta_q, sclSync_q, sclPrev_q;
	logic       sdaMeta_q, sdaSync_q, sdaPrev_q;
	logic       active;
	logic       sclRise, sclFall, startSeen, stopSeen;
	logic [7:0] addrByte;
	logic       addrHit;
	logic       fifoInValid, fifoInReady, fifoOutValid, fifoOutReady;
	logic [7:0] fifoOutData;

	generate
		if (RX_DEPTH < 2) begin : badRxDepth
			$error("receive buffer needs at least two bytes");
		end
	endgenerate

	// Open drain: only the enables move, the drive level stays low
	assign link.devSclOut = 1'b0;
	assign link.devSdaOut = 1'b0;
	assign link.devSclOe  = sclOe_q;
	assign link.devSdaOe  = sdaOe_q;

	// Bus pins cross in through two flops; lines idle high
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			sclMeta_q <= 1'b1;
			sclSync_q <= 1'b1;
			sclPrev_q <= 1'b1;
			sdaMeta_q <= 1'b1;
			sdaSync_q <= 1'b1;
			sdaPrev_q <= 1'b1;
		end else if (clkEn) begin
			sclMeta_q <= link.scl;
			sclSync_q <= sclMeta_q;
			sclPrev_q <= sclSync_q;
			sdaMeta_q <= link.sda;
			sdaSync_q <= sdaMeta_q;
			sdaPrev_q <= sdaSync_q;
		end
	end

	// Clock must be high in both samples so a data edge
	// racing a clock edge is not taken for a condition
	assign active    = serialIfEnable && serialModeBits == MODE_I2C; // [RULE22]
	assign sclRise   = sclSync_q && !sclPrev_q;
	assign sclFall   = !sclSync_q && sclPrev_q;
	assign startSeen = sclSync_q && sclPrev_q
		&& sdaPrev_q && !sdaSync_q; // [RULE11]
	assign stopSeen  = sclSync_q && sclPrev_q && !sdaPrev_q && sdaSync_q;
	assign addrByte  = {shift_q[6:0], sdaSync_q}; // [RULE5]
	assign addrHit   = addrByte[7:ADDR_LSB]
		== ownSlaveAddress[7:ADDR_LSB]; // [RULE3] [RULE4]
	assign fifoInValid = state_q == RX_ACK && phase_q == 2'h2;

	// Bus busy follows conditions seen on the lines
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			busBusyFlag <= 1'b0;
		end else if (clkEn) begin
			if (!active) begin
				busBusyFlag <= 1'b0;
			end else if (startSeen) begin
				busBusyFlag <= 1'b1; // [RULE10]
			end else if (stopSeen) begin
				busBusyFlag <= 1'b0; // [RULE21]
			end
		end
	end

	// Transfer sequencer; the master owns every START
	// [RULE9]
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_q         <= IDLE;
			cnt_q           <= '0;
			phase_q         <= '0;
			shift_q         <= '0;
			sclOe_q         <= 1'b0;
			sdaOe_q         <= 1'b0;
			addrMatchFlag   <= 1'b0;
			byteDoneFlag    <= 1'b0;
			masterRwBit     <= 1'b0;
			receivedAckFlag <= 1'b0;
			serialIrq       <= 1'b0;
		end else if (clkEn) begin
			serialIrq <= 1'b0;
			if (!active) begin
				state_q <= IDLE;
				sclOe_q <= 1'b0; // [RULE23]
				sdaOe_q <= 1'b0; // [RULE23]
			end else if (startSeen) begin
				state_q <= ADDR;
				cnt_q   <= '0;
				// Address byte is a transfer too, so the
				// match interrupt never sees a stale done flag
				byteDoneFlag <= 1'b0; // [RULE2]
				sclOe_q <= 1'b0;
				sdaOe_q <= 1'b0;
			end else if (stopSeen) begin
				state_q <= IDLE;
				sclOe_q <= 1'b0;
				sdaOe_q <= 1'b0;
			end else begin
				unique case (state_q)
				IDLE, IGNORE: begin
					sdaOe_q <= 1'b0; // [RULE24]
				end
				ADDR: if (sclRise) begin
					shift_q <= addrByte;
					cnt_q   <= cnt_q + 4'h1;
					if (cnt_q == LAST_BIT) begin
						addrMatchFlag <= addrHit; // [RULE1]
						if (addrHit) begin
							masterRwBit <= sdaSync_q; // [RULE7]
							serialIrq   <= 1'b1; // [RULE6]
							phase_q     <= '0;
							state_q     <= ADDR_ACK;
						end else begin
							state_q <= IGNORE; // [RULE24]
						end
					end
				end
				ADDR_ACK: if (sclFall) begin
					if (phase_q == 2'h0) begin
						sdaOe_q <= 1'b1; // [RULE12]
						phase_q <= 2'h1;
					end else begin
						sdaOe_q <= 1'b0;
						sclOe_q <= 1'b1; // [RULE13]
						phase_q <= 2'h0;
						state_q <= HOLD;
					end
				end
				HOLD: begin
					// Data settles a cycle before the clock is let go
					if (phase_q == 2'h1) begin
						sclOe_q <= 1'b0;
						cnt_q   <= '0;
						state_q <= TX;
					end else if (txRxSelect && txWrite) begin
						sdaOe_q      <= !txData[7]; // [RULE20]
						shift_q      <= {txData[6:0], 1'b0};
						byteDoneFlag <= 1'b0;
						phase_q      <= 2'h1; // [RULE13]
					end else if (!txRxSelect && dummyRead) begin
						sclOe_q      <= 1'b0; // [RULE13]
						cnt_q        <= '0;
						byteDoneFlag <= 1'b0;
						state_q      <= RX;
					end
				end
				RX: if (sclRise) begin
					shift_q <= {shift_q[6:0], sdaSync_q}; // [RULE16]
					cnt_q   <= cnt_q + 4'h1;
					if (cnt_q == LAST_BIT) begin
						byteDoneFlag <= 1'b1; // [RULE2]
						serialIrq    <= 1'b1; // [RULE2]
						phase_q      <= '0;
						state_q      <= RX_ACK;
					end
				end
				RX_ACK: begin
					if (phase_q == 2'h2) begin
						// Full buffer keeps the clock held low
						if (fifoInReady) begin
							sclOe_q      <= 1'b0;
							cnt_q        <= '0;
							byteDoneFlag <= 1'b0;
							state_q      <= RX;
						end
					end else if (sclFall) begin
						if (phase_q == 2'h0) begin
							sdaOe_q <= !ackToSend; // [RULE19] [RULE17]
							phase_q <= 2'h1;
						end else begin
							sdaOe_q <= 1'b0;
							sclOe_q <= 1'b1;
							phase_q <= 2'h2;
						end
					end
				end
				TX: begin
					if (sclRise) begin
						cnt_q <= cnt_q + 4'h1;
					end else if (sclFall) begin
						if (cnt_q == ALL_BITS) begin
							sdaOe_q <= 1'b0;
							phase_q <= '0;
							state_q <= TX_ACK;
						end else begin
							sdaOe_q <= !shift_q[7]; // [RULE16]
							shift_q <= {shift_q[6:0], 1'b0};
						end
					end
				end
				TX_ACK: begin
					if (sclRise) begin
						receivedAckFlag <= sdaSync_q; // [RULE18]
						byteDoneFlag    <= 1'b1; // [RULE2]
						serialIrq       <= 1'b1;
						if (sdaSync_q) begin
							state_q <= IGNORE; // [RULE18]
						end else begin
							phase_q <= 2'h1;
						end
					end else if (sclFall && phase_q == 2'h1) begin
						sclOe_q <= 1'b1; // [RULE13]
						phase_q <= '0;
						state_q <= HOLD;
					end
				end
				default: state_q <= IDLE;
				endcase
			end
		end
	end

	// Received bytes queue up; a holding stage feeds software
	fifo_buffer #(
		.WIDTH (BYTE_BITS),
		.DEPTH (RX_DEPTH)
	) rxFifo (
		.mclk     (mclk),
		.rst      (rst),
		.clkEn    (clkEn),
		.inValid  (fifoInValid),
		.inReady  (fifoInReady),
		.inData   (shift_q),
		.outValid (fifoOutValid),
		.outReady (fifoOutReady),
		.outData  (fifoOutData)
	);

	assign fifoOutReady = !rxValid || rxReady;

	// Output byte held in a flop so the port is registered
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rxValid <= 1'b0;
			rxData  <= '0;
		end else if (clkEn && fifoOutReady) begin
			rxValid <= fifoOutValid;
			rxData  <= fifoOutData; // [RULE20]
		end
	end
endmodule

// [logic/i2c_bus_master.sv]
`timescale 1ns/1ps
module i2c_bus_master
	import i2c_link_pkg::*;
#(
	parameter int QUARTER = QUARTER_CYC
) (
	// Clock, reset and clock enable
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic       clkEn,
	// Two-wire link
	i2c_link_if.mst         link,
	// One-byte transfer request
	input  wire logic       cmdValid,
	output logic            cmdReady,
	input  wire logic [6:0] cmdAddr,
	input  wire logic       cmdRead,
	input  wire logic [7:0] cmdData,
	// Completion report
	output logic            doneValid,
	output logic            doneNack,
	output logic      [7:0] doneData
);
	typedef enum logic [1:0] {IDLE, START, BIT, STOP} mstState_t;

	localparam logic [15:0] TMR_LOAD = 16'(QUARTER - 1);
	localparam logic [4:0]  ACK_A    = 5'(ACK_A_IDX);
	localparam logic [4:0]  LAST     = 5'(LAST_IDX);

	mstState_t   state_q;
	logic [15:0] tmr_q;
	logic [1:0]  phase_q;
	logic [4:0]  idx_q;
	logic [6:0]  addr_q;
	logic        read_q;
	logic [7:0]  data_q;
	logic        sclOe_q, sdaOe_q;
	logic        sclMeta_q, sclSync_q, sdaMeta_q, sdaSync_q;
	logic        tmrDone, bitNow;
	logic [7:0]  addrByte;

	// Slave reacts a few cycles after an edge; shorter quarters race it
	generate
		if (QUARTER < 8 || QUARTER > 65535) begin : badQuarter
			$error("quarter period must be 8 to 65535 cycles");
		end
	endgenerate

	assign link.mstSclOut = 1'b0;
	assign link.mstSdaOut = 1'b0;
	assign link.mstSclOe  = sclOe_q;
	assign link.mstSdaOe  = sdaOe_q;

	assign tmrDone  = tmr_q == '0;
	assign addrByte = {addr_q, read_q};
	// Frame: address MSB first, ack slot, data MSB first, ack slot
	always_comb begin
		if (idx_q < ACK_A) begin
			bitNow = addrByte[3'(5'h7 - idx_q)]; // [RULE5]
		end else if (idx_q > ACK_A && idx_q < LAST && !read_q) begin
			// Register shifts once per bit, top bit is next
			bitNow = data_q[7]; // [RULE16]
		end else begin
			bitNow = 1'b1;
		end
	end

	// Lines read back through two flops; the slave may stretch
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			sclMeta_q <= 1'b1;
			sclSync_q <= 1'b1;
			sdaMeta_q <= 1'b1;
			sdaSync_q <= 1'b1;
		end else if (clkEn) begin
			sclMeta_q <= link.scl;
			sclSync_q <= sclMeta_q;
			sdaMeta_q <= link.sda;
			sdaSync_q <= sdaMeta_q;
		end
	end

	// Clock divider and bit sequencer in quarter periods
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_q   <= IDLE;
			tmr_q     <= '0;
			phase_q   <= '0;
			idx_q     <= '0;
			addr_q    <= '0;
			read_q    <= 1'b0;
			data_q    <= '0;
			sclOe_q   <= 1'b0;
			sdaOe_q   <= 1'b0;
			cmdReady  <= 1'b0;
			doneValid <= 1'b0;
			doneNack  <= 1'b0;
			doneData  <= '0;
		end else if (clkEn) begin
			doneValid <= 1'b0;
			if (!tmrDone) begin
				tmr_q <= tmr_q - 16'h1;
			end
			unique case (state_q)
			IDLE: begin
				cmdReady <= 1'b1;
				if (cmdValid && cmdReady) begin
					cmdReady <= 1'b0;
					addr_q   <= cmdAddr;
					read_q   <= cmdRead;
					data_q   <= cmdData;
					doneNack <= 1'b0;
					phase_q  <= '0;
					tmr_q    <= TMR_LOAD;
					state_q  <= START;
				end
			end
			START: if (tmrDone) begin
				tmr_q <= TMR_LOAD;
				if (phase_q == 2'h0) begin
					sdaOe_q <= 1'b1; // [RULE11] [RULE9]
					phase_q <= 2'h1;
				end else begin
					sclOe_q <= 1'b1;
					idx_q   <= '0;
					phase_q <= '0;
					state_q <= BIT;
				end
			end
			BIT: begin
				unique case (phase_q)
				2'h0: if (tmrDone) begin
					sdaOe_q <= !bitNow; // [RULE17]
					tmr_q   <= TMR_LOAD;
					phase_q <= 2'h1;
				end
				2'h1: if (tmrDone) begin
					sclOe_q <= 1'b0;
					phase_q <= 2'h2;
				end
				2'h2: if (sclSync_q) begin
					tmr_q   <= TMR_LOAD;
					phase_q <= 2'h3;
				end
				2'h3: if (tmrDone) begin
					sclOe_q <= 1'b1;
					tmr_q   <= TMR_LOAD;
					phase_q <= 2'h0;
					idx_q   <= idx_q + 5'h1;
					if (idx_q > ACK_A && idx_q < LAST) begin
						data_q <= {data_q[6:0], sdaSync_q};
					end
					if (idx_q == ACK_A && sdaSync_q) begin
						doneNack <= 1'b1;
						state_q  <= STOP; // [RULE15]
					end else if (idx_q == LAST) begin
						doneNack <= !read_q && sdaSync_q;
						state_q  <= STOP;
					end
				end
				endcase
			end
			STOP: begin
				unique case (phase_q)
				2'h0: if (tmrDone) begin
					sdaOe_q <= 1'b1;
					tmr_q   <= TMR_LOAD;
					phase_q <= 2'h1;
				end
				2'h1: if (tmrDone) begin
					sclOe_q <= 1'b0;
					phase_q <= 2'h2;
				end
				2'h2: if (sclSync_q) begin
					tmr_q   <= TMR_LOAD;
					phase_q <= 2'h3;
				end
				2'h3: if (tmrDone) begin
					sdaOe_q   <= 1'b0;
					doneValid <= 1'b1;
					doneData  <= data_q;
					state_q   <= IDLE;
				end
				endcase
			end
			endcase
		end
	end
endmodule

// [verification/i2c_link_asserts.sv]
`timescale 1ns/1ps
module i2c_link_asserts (
	// Clock and reset
	input logic mclk,
	input logic rst,
	// Wire levels and enables
	input logic devSclOe,
	input logic devSdaOe,
	input logic mstSdaOe,
	input logic scl,
	input logic sda
);
	logic       sclQ;
	logic       sdaQ;
	logic       rwBit;
	logic [4:0] bitCnt;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	// Previous wire levels, idle high like the pull-ups
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			sclQ <= 1'b1;
			sdaQ <= 1'b1;
		end else begin
			sclQ <= scl;
			sdaQ <= sda;
		end
	end

	// Clock rises since the last start, saturating
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			bitCnt <= 5'h00;
		else if (scl && sclQ && sdaQ && !sda)
			bitCnt <= 5'h00;
		else if (scl && !sclQ && bitCnt != 5'h1F)
			bitCnt <= bitCnt + 5'h01;
	end

	// Direction bit of the frame in flight
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			rwBit <= 1'b0;
		else if (scl && !sclQ && bitCnt == 5'h07)
			rwBit <= sda;
	end

	chk_no_dev_start: assert property (
		$rose(devSdaOe) |-> !scl)
		else $error("device pulled data low with clock high");
	chk_dev_release: assert property (
		$fell(devSdaOe) |-> !scl)
		else $error("device released data with clock high");
	chk_hold_low: assert property (
		$rose(devSclOe) |-> !scl)
		else $error("device grabbed clock while high");
	chk_addr_quiet: assert property (
		$rose(scl) && bitCnt < 5'h08 |-> !devSdaOe)
		else $error("device drove data during address");
	chk_ack_held: assert property (
		$rose(scl) && devSdaOe |=> devSdaOe [*3])
		else $error("device low level not held");
	chk_rd_release: assert property (
		$rose(scl) && rwBit && bitCnt == 5'h11 |-> !devSdaOe)
		else $error("device held data at read ack");
	chk_rd_mst_quiet: assert property (
		$rose(scl) && rwBit && bitCnt > 5'h08 && bitCnt < 5'h11
		|-> !mstSdaOe)
		else $error("master drove data during read byte");
	chk_high_phase: assert property (
		scl && $past(scl) && sda != $past(sda) |-> $stable(devSdaOe))
		else $error("device moved data while clock high");
	chk_frame_len: assert property (
		$rose(scl) |-> bitCnt < 5'h12 || (bitCnt == 5'h12 && !sda))
		else $error("frame longer than eighteen clocks and stop");
endmodule

// [verification/i2c_slave_interface_tb_top.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
	n_tests++; \
	if ((g) !== (e)) begin \
		failures++; \
		$display("ERROR %s expected %0h seen %0h", nm, e, g); \
	end \
end
module i2c_slave_interface_tb_top
	import i2c_link_pkg::*;
;
	logic       mclk            = 1'b0;
	logic       rst             = 1'b1;
	logic       clkEn           = 1'b1;
	logic       serialIfEnable  = 1'b0;
	logic [2:0] serialModeBits  = 3'h0;
	logic [7:0] ownSlaveAddress = 8'h00;
	logic       txRxSelect      = 1'b0;
	logic       ackToSend       = 1'b0;
	logic       txWrite         = 1'b0;
	logic [7:0] txData          = 8'h00;
	logic       dummyRead       = 1'b0;
	logic       rxReady         = 1'b1;
	logic       cmdValid        = 1'b0;
	logic [6:0] cmdAddr         = 7'h00;
	logic       cmdRead         = 1'b0;
	logic [7:0] cmdData         = 8'h00;
	logic [7:0] txByte          = 8'h00;
	logic       pend            = 1'b0;
	logic       busySeen        = 1'b0;
	logic       rxValid;
	logic [7:0] rxData;
	logic       addrMatchFlag;
	logic       byteDoneFlag;
	logic       busBusyFlag;
	logic       masterRwBit;
	logic       receivedAckFlag;
	logic       serialIrq;
	logic       cmdReady;
	logic       doneValid;
	logic       doneNack;
	logic [7:0] doneData;
	logic [7:0] rxQ[$];
	logic [7:0] expQ[$];
	int         irqCnt          = 0;
	int         failures        = 0;
	int         n_tests         = 0;

	i2c_link_if i_i2c_link_if ();

	i2c_slave_interface #(.RX_DEPTH(FIFO_WORDS)) i_i2c_slave_interface (
		.mclk(mclk), .rst(rst), .clkEn(clkEn), .link(i_i2c_link_if),
		.ownSlaveAddress(ownSlaveAddress), .serialIfEnable(serialIfEnable),
		.serialModeBits(serialModeBits), .txRxSelect(txRxSelect),
		.ackToSend(ackToSend), .txWrite(txWrite), .txData(txData),
		.dummyRead(dummyRead), .rxValid(rxValid), .rxReady(rxReady),
		.rxData(rxData), .addrMatchFlag(addrMatchFlag),
		.byteDoneFlag(byteDoneFlag), .busBusyFlag(busBusyFlag),
		.masterRwBit(masterRwBit), .receivedAckFlag(receivedAckFlag),
		.serialIrq(serialIrq));

	// Short quarter bit keeps the run brief
	i2c_bus_master #(.QUARTER(8)) i_i2c_bus_master (
		.mclk(mclk), .rst(rst), .clkEn(clkEn), .link(i_i2c_link_if),
		.cmdValid(cmdValid), .cmdReady(cmdReady), .cmdAddr(cmdAddr),
		.cmdRead(cmdRead), .cmdData(cmdData), .doneValid(doneValid),
		.doneNack(doneNack), .doneData(doneData));

	i2c_link_asserts i_i2c_link_asserts (
		.mclk(mclk), .rst(rst), .devSclOe(i_i2c_link_if.devSclOe),
		.devSdaOe(i_i2c_link_if.devSdaOe),
		.mstSdaOe(i_i2c_link_if.mstSdaOe),
		.scl(i_i2c_link_if.scl), .sda(i_i2c_link_if.sda));

	// Clock and reset
	always #5 mclk = ~mclk;
	initial begin
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
	end

	// Slave software: serve the match only once the clock is held;
	// each strobe gets one assignment per edge
	always @(posedge mclk) begin
		txWrite   <= pend && i_i2c_link_if.devSclOe && txRxSelect;
		dummyRead <= pend && i_i2c_link_if.devSclOe && !txRxSelect;
		if (pend && i_i2c_link_if.devSclOe) begin
			pend   <= 1'b0;
			txData <= txByte;
		end
		if (serialIrq) begin
			irqCnt <= irqCnt + 1;
			busySeen <= busBusyFlag;
		end
		if (serialIrq && addrMatchFlag && !byteDoneFlag) begin
			txRxSelect <= masterRwBit;
			pend <= 1'b1;
		end
		if (rxValid && rxReady)
			rxQ.push_back(rxData);
	end

	// One master command, then its outcome
	task automatic xfer(input logic [6:0] a, input logic rd,
		input logic [7:0] d, input logic nackExp, input int irqs);
		int i0;
		int n;
		i0 = irqCnt;
		n = 0;
		@(posedge mclk);
		while (!cmdReady) @(posedge mclk);
		cmdAddr <= a;
		cmdRead <= rd;
		cmdData <= d;
		cmdValid <= 1'b1;
		@(posedge mclk);
		cmdValid <= 1'b0;
		do begin
			@(posedge mclk);
			n++;
		end while (!doneValid && n < 4000);
		`CHK("done", 1'b1, doneValid)
		`CHK("nack", nackExp, doneNack)
		repeat (8) @(posedge mclk);
		`CHK("irqs", irqs, irqCnt - i0)
		`CHK("busy", 1'b0, busBusyFlag)
	endtask

	task automatic final_report;
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Hang guard, about twice the expected run
	initial begin
		repeat (50000) @(posedge mclk);
		`CHK("watchdog", 1'b0, 1'b1)
		final_report;
	end

	initial begin
		wait (!rst);
		// Address first, then enable and mode
		@(posedge mclk);
		ownSlaveAddress <= 8'hA4;
		@(posedge mclk);
		serialIfEnable <= 1'b1;
		serialModeBits <= MODE_I2C;
		xfer(7'h52, 1'b0, 8'hA5, 1'b0, 2);
		expQ.push_back(8'hA5);
		`CHK("match", 1'b1, addrMatchFlag)
		`CHK("rw", 1'b0, masterRwBit)
		`CHK("busySeen", 1'b1, busySeen)
		txByte <= 8'h3C;
		xfer(7'h52, 1'b1, 8'h00, 1'b0, 2);
		`CHK("rdData", 8'h3C, doneData)
		`CHK("rw", 1'b1, masterRwBit)
		`CHK("byteDone", 1'b1, byteDoneFlag)
		`CHK("rxAck", 1'b1, receivedAckFlag)
		// Wrong address, one of them shifted by a bit
		for (int i = 0; i < 2; i++) begin
			xfer(i ? 7'h29 : 7'h53, 1'b0, 8'h66, 1'b1, 0);
			`CHK("match", 1'b0, addrMatchFlag)
		end
		// Bit 0 of the own address has no say
		ownSlaveAddress <= 8'hA5;
		xfer(7'h52, 1'b0, 8'h5A, 1'b0, 2);
		expQ.push_back(8'h5A);
		// Refusal of a data byte
		ackToSend <= 1'b1;
		xfer(7'h52, 1'b0, 8'h81, 1'b1, 2);
		expQ.push_back(8'h81);
		ackToSend <= 1'b0;
		// Switched off, then the wrong mode
		serialIfEnable <= 1'b0;
		xfer(7'h52, 1'b0, 8'h11, 1'b1, 0);
		serialIfEnable <= 1'b1;
		serialModeBits <= 3'h5;
		xfer(7'h52, 1'b0, 8'h22, 1'b1, 0);
		serialModeBits <= MODE_I2C;
		// Fill buffer and output stage while the reader stalls
		rxReady <= 1'b0;
		for (int i = 0; i <= FIFO_WORDS; i++) begin
			xfer(7'h52, 1'b0, 8'(i * 7), 1'b0, 2);
			expQ.push_back(8'(i * 7));
		end
		fork
			xfer(7'h52, 1'b0, 8'hEE, 1'b0, 2);
			begin
				repeat (3000) @(posedge mclk);
				`CHK("stretch", 1'b1, i_i2c_link_if.devSclOe)
				rxReady <= 1'b1;
			end
		join
		expQ.push_back(8'hEE);
		repeat (200) @(posedge mclk);
		`CHK("rxCount", expQ.size(), rxQ.size())
		foreach (expQ[i])
			`CHK("rxData", expQ[i], rxQ[i])
		final_report;
	end
endmodule
